/* logic/atc_pkg.sv */
/*
 * Constants for the acquisition trigger control block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
 */
// Overview of operation
// RULE1 - software start begins acquisition when untriggered
// RULE2 - stop on count, reference trigger, or software
// RULE3 - programmable delay from start to first sample
// RULE4 - digital start: selectable source, selectable edge
// RULE5 - analog start acts on first rising edge
// RULE6 - routed start trigger is active-high pulse
// RULE7 - posttrigger count equals buffer minus pretrigger
// RULE8 - reference trigger armed after pretrigger samples
// RULE9 - full buffer overwrites oldest sample
// RULE10 - store posttrigger samples then end acquisition
// RULE11 - digital reference: selectable source and edge
// RULE12 - analog reference stops on configured edge
// RULE13 - routed reference trigger active high by default
// RULE14 - pause halts sample clock at active level
// RULE15 - pause trigger is level sensitive only
// RULE16 - analog pause suspends at configured level
// RULE17 - synchronise external trigger inputs before detection
// RULE18 - flag completion of finite acquisition
package atc_pkg;
    localparam int          ADDR_W        = 5;
    localparam int          NUM_TERM      = 8;
    localparam int          NUM_CTR       = 4;
    localparam int          SRC_W         = 4;

    localparam logic [4:0]  OFS_CTRL      = 5'h00;
    localparam logic [4:0]  OFS_TRIG      = 5'h04;
    localparam logic [4:0]  OFS_DELAY     = 5'h08;
    localparam logic [4:0]  OFS_COUNT     = 5'h0C;
    localparam logic [4:0]  OFS_PRE       = 5'h10;
    localparam logic [4:0]  OFS_STATUS    = 5'h14;
    localparam logic [4:0]  OFS_IRQ_STAT  = 5'h18;
    localparam logic [4:0]  OFS_IRQ_MASK  = 5'h1C;

    // control register bits (write-one commands plus mode)
    localparam int          CTRL_SW_START = 0;
    localparam int          CTRL_SW_STOP  = 1;
    localparam int          CTRL_FINITE   = 2;
    localparam int          CTRL_REF_EN   = 3;
    localparam int          CTRL_INT_CLK  = 4;

    // trigger configuration fields
    localparam int          TRG_ST_EN     = 0;
    localparam int          TRG_ST_FALL   = 1;
    localparam int          TRG_ST_SRC    = 4;
    localparam int          TRG_RF_FALL   = 8;
    localparam int          TRG_RF_SRC    = 12;
    localparam int          TRG_PS_EN     = 16;
    localparam int          TRG_PS_LOW    = 17;
    localparam int          TRG_PS_SRC    = 20;
    localparam int          TRG_ST_OUT_EN = 24;
    localparam int          TRG_RF_OUT_EN = 25;
    localparam int          TRG_RF_OUT_LO = 26;

    // source codes: 0..7 terminal, 8..11 counter, 12 analog event
    localparam logic [3:0]  SRC_CTR_BASE  = 4'h8;
    localparam logic [3:0]  SRC_ANALOG    = 4'hC;

    // interrupt / status bits
    localparam int          EV_DONE       = 0;
    localparam int          EV_STARTED    = 1;
    localparam int          EV_REF        = 2;
    localparam int          EV_W          = 3;

    localparam logic [31:0] RST_TRIG      = 32'h0000_0000;
    localparam logic [31:0] RST_DELAY     = 32'h0000_0000;
    localparam logic [31:0] RST_COUNT     = 32'h0000_0400;
    localparam logic [31:0] RST_PRE       = 32'h0000_0000;
    localparam logic [31:0] RD_UNMAPPED   = 32'h0000_0000;

    localparam int          SYNC_STAGES   = 2;
    localparam int          PULSE_CYC     = 4;
endpackage

/* logic/atc_sync.sv */
/*
 * Two-stage synchroniser bank for trigger inputs.
 * Assumes inputs are slow relative to the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module atc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_in;
            sync_q <= meta_q;
        end
    end

    assign q_out = sync_q;
endmodule
`default_nettype wire

/* logic/atc_top.sv */
/*
 * Acquisition trigger control: start, reference and pause triggers,
 * sample gating, pretrigger/posttrigger counting, Avalon-MM registers.
 * Assumes SAMPLE_TICK_IN marks sample clock ticks from a generator
 * outside and that all trigger inputs arrive asynchronously.
 */
`timescale 1ns/1ps
`default_nettype none
module atc_top
    import atc_pkg::*;
(
    input  wire logic                SYS_CLK_IN,
    input  wire logic                SYS_RST_IN,
    input  wire logic [ADDR_W-1:0]   AVS_ADDRESS_IN,
    input  wire logic                AVS_READ_IN,
    input  wire logic                AVS_WRITE_IN,
    input  wire logic [31:0]         AVS_WRITEDATA_IN,
    input  wire logic [3:0]          AVS_BYTEENABLE_IN,
    output logic      [31:0]         AVS_READDATA_OUT,
    output logic                     AVS_WAITREQUEST_OUT,
    input  wire logic [NUM_TERM-1:0] TERMINAL_IN,
    input  wire logic [NUM_CTR-1:0]  COUNTER_OUT_IN,
    input  wire logic                ANALOG_EVENT_IN,
    input  wire logic                SAMPLE_TICK_IN,
    output logic                     SAMPLE_OUT,
    output logic                     WRITE_STROBE_OUT,
    output logic                     START_TRIG_OUT,
    output logic                     REF_TRIG_OUT,
    output logic                     RUNNING_OUT,
    output logic                     IRQ_OUT
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_WAIT_START, ST_DELAY, ST_RUN, ST_POST
    } atc_state_e;

    localparam int SYN_W = NUM_TERM + NUM_CTR + 1;

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    function automatic logic pick_src(input logic [3:0] sel,
                                      input logic [SYN_W-1:0] v);
        logic r;
        r = 1'b0;
        if (sel < SRC_CTR_BASE) begin
            r = v[sel[2:0]];
        end else if (sel < SRC_ANALOG) begin
            r = v[NUM_TERM + 32'(sel - SRC_CTR_BASE)];
        end else if (sel == SRC_ANALOG) begin
            r = v[SYN_W-1];
        end
        return r;
    endfunction

    function automatic logic edge_hit(input logic now, input logic was,
                                      input logic fall);
        return fall ? (was & ~now) : (now & ~was);
    endfunction

    function automatic logic [31:0] merge_be(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // trigger input synchronisers
    // ------------------------------------------------------------------
    logic [SYN_W-1:0] syn;

    atc_sync #(
        .W (SYN_W)
    ) u_sync (
        .clk_in (SYS_CLK_IN),
        .rst_in (SYS_RST_IN),
        .d_in   ({ANALOG_EVENT_IN, COUNTER_OUT_IN, TERMINAL_IN}), // [RULE17]
        .q_out  (syn)
    );

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [31:0]     ctrl_q;
    logic [31:0]     trig_q;
    logic [31:0]     delay_q;
    logic [31:0]     count_q;
    logic [31:0]     pre_q;
    logic [EV_W-1:0] irq_stat_q;
    logic [EV_W-1:0] irq_mask_q;
    logic            wr_acc;
    logic            rd_acc;
    logic            sw_start;
    logic            sw_stop;

    assign wr_acc   = AVS_WRITE_IN & ~AVS_WAITREQUEST_OUT;
    assign rd_acc   = AVS_READ_IN & AVS_WAITREQUEST_OUT;
    assign sw_start = wr_acc && AVS_ADDRESS_IN == OFS_CTRL &&
                      AVS_BYTEENABLE_IN[0] && AVS_WRITEDATA_IN[CTRL_SW_START];
    assign sw_stop  = wr_acc && AVS_ADDRESS_IN == OFS_CTRL &&
                      AVS_BYTEENABLE_IN[0] && AVS_WRITEDATA_IN[CTRL_SW_STOP];

    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            ctrl_q  <= '0;
            trig_q  <= RST_TRIG;
            delay_q <= RST_DELAY;
            count_q <= RST_COUNT;
            pre_q   <= RST_PRE;
        end else if (wr_acc) begin
            case (AVS_ADDRESS_IN)
                OFS_CTRL:  ctrl_q  <= merge_be(ctrl_q, AVS_WRITEDATA_IN,
                                               AVS_BYTEENABLE_IN) & 32'h0000_001C;
                OFS_TRIG:  trig_q  <= merge_be(trig_q, AVS_WRITEDATA_IN,
                                               AVS_BYTEENABLE_IN);
                OFS_DELAY: delay_q <= merge_be(delay_q, AVS_WRITEDATA_IN,
                                               AVS_BYTEENABLE_IN);
                OFS_COUNT: count_q <= merge_be(count_q, AVS_WRITEDATA_IN,
                                               AVS_BYTEENABLE_IN);
                OFS_PRE:   pre_q   <= merge_be(pre_q, AVS_WRITEDATA_IN,
                                               AVS_BYTEENABLE_IN);
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // trigger detection
    // ------------------------------------------------------------------
    logic       st_lvl;
    logic       rf_lvl;
    logic       ps_lvl;
    logic       st_prev_q;
    logic       rf_prev_q;
    logic       st_hit;
    logic       rf_hit;
    logic       st_analog;
    logic       paused;

    assign st_lvl    = pick_src(trig_q[TRG_ST_SRC +: SRC_W], syn); // [RULE4]
    assign rf_lvl    = pick_src(trig_q[TRG_RF_SRC +: SRC_W], syn); // [RULE11]
    assign ps_lvl    = pick_src(trig_q[TRG_PS_SRC +: SRC_W], syn);
    assign st_analog = trig_q[TRG_ST_SRC +: SRC_W] == SRC_ANALOG;

    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            st_prev_q <= 1'b0;
            rf_prev_q <= 1'b0;
        end else begin
            st_prev_q <= st_lvl;
            rf_prev_q <= rf_lvl;
        end
    end

    // analog start ignores the edge setting and takes rising only
    assign st_hit = edge_hit(st_lvl, st_prev_q,
                             trig_q[TRG_ST_FALL] & ~st_analog); // [RULE4] [RULE5]
    // analog reference uses the configured edge as a digital one does
    assign rf_hit = edge_hit(rf_lvl, rf_prev_q, trig_q[TRG_RF_FALL]); // [RULE11] [RULE12]
    // pause looks only at the level, digital or analog alike
    assign paused = trig_q[TRG_PS_EN] &
                    (ps_lvl ^ trig_q[TRG_PS_LOW]); // [RULE14] [RULE15] [RULE16]

    // ------------------------------------------------------------------
    // acquisition sequencer
    // ------------------------------------------------------------------
    atc_state_e  state_q;
    atc_state_e  state_d;
    logic [31:0] delay_cnt_q;
    logic [31:0] smp_cnt_q;
    logic [31:0] post_cnt_q;
    logic [31:0] post_target;
    logic        take;
    logic        done_ev;
    logic        start_ev;
    logic        ref_ev;
    logic        armed;

    assign take        = (state_q == ST_RUN || state_q == ST_POST) &&
                         SAMPLE_TICK_IN && !paused; // [RULE14]
    assign post_target = count_q - pre_q; // [RULE7]
    assign armed       = smp_cnt_q >= pre_q; // [RULE8]
    assign ref_ev      = state_q == ST_RUN && ctrl_q[CTRL_FINITE] &&
                         ctrl_q[CTRL_REF_EN] && armed && rf_hit; // [RULE8]
    assign start_ev    = (state_q == ST_WAIT_START && st_hit) ||
                         (state_q == ST_IDLE && sw_start && !trig_q[TRG_ST_EN]);

    always_comb begin
        state_d = state_q;
        done_ev = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (sw_start) begin
                    state_d = trig_q[TRG_ST_EN] ? ST_WAIT_START : ST_DELAY; // [RULE1]
                end
            end
            ST_WAIT_START: begin
                if (sw_stop) begin
                    state_d = ST_IDLE;
                end else if (st_hit) begin
                    state_d = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (sw_stop) begin
                    state_d = ST_IDLE;
                end else if (!ctrl_q[CTRL_INT_CLK] || delay_cnt_q >= delay_q) begin
                    state_d = ST_RUN; // [RULE3]
                end
            end
            ST_RUN: begin
                if (!ctrl_q[CTRL_FINITE]) begin
                    if (sw_stop) begin
                        state_d = ST_IDLE; // [RULE2]
                    end
                end else if (ref_ev) begin
                    state_d = ST_POST; // [RULE2]
                end else if (!ctrl_q[CTRL_REF_EN] && take &&
                             smp_cnt_q + 32'h1 >= count_q) begin
                    state_d = ST_IDLE; // [RULE2]
                    done_ev = 1'b1;
                end else if (sw_stop) begin
                    state_d = ST_IDLE;
                end
            end
            ST_POST: begin
                if (take && post_cnt_q + 32'h1 >= post_target) begin
                    state_d = ST_IDLE; // [RULE10]
                    done_ev = 1'b1;
                end else if (sw_stop) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN || state_q != ST_DELAY) begin
            delay_cnt_q <= '0;
        end else begin
            delay_cnt_q <= delay_cnt_q + 32'h1; // [RULE3]
        end
    end

    // samples before trigger keep counting; write strobe wraps the ring
    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN || state_q == ST_DELAY) begin
            smp_cnt_q  <= '0;
            post_cnt_q <= '0;
        end else if (take) begin
            if (state_q == ST_RUN && smp_cnt_q != 32'hFFFF_FFFF) begin
                smp_cnt_q <= smp_cnt_q + 32'h1;
            end
            if (state_q == ST_POST) begin
                post_cnt_q <= post_cnt_q + 32'h1; // [RULE10]
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    logic [2:0] st_pulse_q;

    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            SAMPLE_OUT       <= 1'b0;
            WRITE_STROBE_OUT <= 1'b0;
            RUNNING_OUT      <= 1'b0;
        end else begin
            SAMPLE_OUT       <= take;
            // each write goes over the oldest once the ring is full
            WRITE_STROBE_OUT <= take; // [RULE9]
            RUNNING_OUT      <= state_d == ST_RUN || state_d == ST_POST;
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            st_pulse_q     <= '0;
            START_TRIG_OUT <= 1'b0;
        end else begin
            if (start_ev) begin
                st_pulse_q <= 3'(PULSE_CYC - 1);
            end else if (st_pulse_q != 3'h0) begin
                st_pulse_q <= st_pulse_q - 3'h1;
            end
            START_TRIG_OUT <= trig_q[TRG_ST_OUT_EN] &
                              (start_ev | (st_pulse_q != 3'h0)); // [RULE6]
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            REF_TRIG_OUT <= 1'b0;
        end else begin
            // one-cycle pulse output, inverted only when asked
            REF_TRIG_OUT <= trig_q[TRG_RF_OUT_EN] &
                            (ref_ev ^ trig_q[TRG_RF_OUT_LO]); // [RULE13]
        end
    end

    // ------------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------------
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;

    assign ev_set = {ref_ev, start_ev, done_ev}; // [RULE18]
    assign ev_clr = (wr_acc && AVS_ADDRESS_IN == OFS_IRQ_STAT &&
                     AVS_BYTEENABLE_IN[0]) ? AVS_WRITEDATA_IN[EV_W-1:0] : '0;

    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            IRQ_OUT    <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~ev_clr) | ev_set; // [RULE18]
            if (wr_acc && AVS_ADDRESS_IN == OFS_IRQ_MASK && AVS_BYTEENABLE_IN[0]) begin
                irq_mask_q <= AVS_WRITEDATA_IN[EV_W-1:0];
            end
            IRQ_OUT <= |(((irq_stat_q & ~ev_clr) | ev_set) & irq_mask_q);
        end
    end

    // ------------------------------------------------------------------
    // bus answer: one wait cycle then ack
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            AVS_WAITREQUEST_OUT <= 1'b1;
            AVS_READDATA_OUT    <= '0;
        end else begin
            AVS_WAITREQUEST_OUT <= !((AVS_READ_IN || AVS_WRITE_IN) &&
                                     AVS_WAITREQUEST_OUT);
            if (rd_acc) begin
                case (AVS_ADDRESS_IN)
                    OFS_CTRL:     AVS_READDATA_OUT <= ctrl_q;
                    OFS_TRIG:     AVS_READDATA_OUT <= trig_q;
                    OFS_DELAY:    AVS_READDATA_OUT <= delay_q;
                    OFS_COUNT:    AVS_READDATA_OUT <= count_q;
                    OFS_PRE:      AVS_READDATA_OUT <= pre_q;
                    OFS_STATUS:   AVS_READDATA_OUT <= {28'h0, armed, paused,
                                                       (state_q == ST_POST),
                                                       RUNNING_OUT};
                    OFS_IRQ_STAT: AVS_READDATA_OUT <= {29'h0, irq_stat_q};
                    OFS_IRQ_MASK: AVS_READDATA_OUT <= {29'h0, irq_mask_q};
                    default:      AVS_READDATA_OUT <= RD_UNMAPPED;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* verif/atc_sva.sv */
/*
 * Port checker for atc_top: bus handshake, sample path, start pulse.
 * Assumes one clock domain with synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module atc_sva (
    input wire logic        SYS_CLK_IN,
    input wire logic        SYS_RST_IN,
    input wire logic        AVS_READ_IN,
    input wire logic        AVS_WRITE_IN,
    input wire logic [31:0] AVS_READDATA_OUT,
    input wire logic        AVS_WAITREQUEST_OUT,
    input wire logic        SAMPLE_TICK_IN,
    input wire logic        SAMPLE_OUT,
    input wire logic        WRITE_STROBE_OUT,
    input wire logic        START_TRIG_OUT,
    input wire logic        RUNNING_OUT
);
    // ----------
    // assertions
    // ----------
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);
    wire logic req = AVS_READ_IN || AVS_WRITE_IN;
    sequence s_bus_ask;
        req && AVS_WAITREQUEST_OUT;
    endsequence
    sequence s_start_hold;
        START_TRIG_OUT [*4] ##1 !START_TRIG_OUT;
    endsequence
    AST_BUS_ANSWER: assert property (s_bus_ask |=> !AVS_WAITREQUEST_OUT)
        else $error("waitrequest did not fall after request");
    AST_BUS_ONE: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
        else $error("waitrequest low longer than one cycle");
    AST_BUS_IDLE: assert property (!req |=> AVS_WAITREQUEST_OUT)
        else $error("waitrequest low without request");
    AST_RDATA_HOLD: assert property (!AVS_READ_IN |=> $stable(AVS_READDATA_OUT))
        else $error("read data changed without read");
    AST_SAMPLE_TICK: assert property (SAMPLE_OUT |-> $past(SAMPLE_TICK_IN))
        else $error("sample without tick");
    AST_STROBE_EQ: assert property (WRITE_STROBE_OUT == SAMPLE_OUT)
        else $error("write strobe differs from sample");
    AST_SAMPLE_RUN: assert property (SAMPLE_OUT |-> RUNNING_OUT || $past(RUNNING_OUT))
        else $error("sample outside acquisition");
    AST_START_PULSE: assert property ($rose(START_TRIG_OUT) |-> s_start_hold)
        else $error("start pulse width wrong");
endmodule
bind atc_top atc_sva u_sva (.SYS_CLK_IN, .SYS_RST_IN, .AVS_READ_IN, .AVS_WRITE_IN,
    .AVS_READDATA_OUT, .AVS_WAITREQUEST_OUT, .SAMPLE_TICK_IN, .SAMPLE_OUT,
    .WRITE_STROBE_OUT, .START_TRIG_OUT, .RUNNING_OUT);
`default_nettype wire

/* verif/atc_tick_gen.sv */
/*
 * Sample tick source standing in for the sample clock generator.
 * Assumes the block's clock and reset; emits one-cycle pulses.
 */
`timescale 1ns/1ps
`default_nettype none
module atc_tick_gen (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] period_in,
    output logic            tick_out
);
    // ------------
    // tick counter
    // ------------
    logic [7:0] cnt_q;
    always_ff @(posedge clk_in) begin
        if (rst_in || cnt_q == period_in - 8'h01) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    always_ff @(posedge clk_in) begin
        tick_out <= !rst_in && cnt_q == period_in - 8'h01;
    end
endmodule
`default_nettype wire

/* verif/atc_top_tb.sv */
/*
 * Self-checking bench for atc_top: registers, interrupt, start, reference
 * and pause triggers. Assumes atc_tick_gen for ticks and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
module atc_top_tb
    import atc_pkg::*;
;
    localparam int SS[4] = '{3, 3, 9, 12};
    localparam int SR[4] = '{1, 0, 1, 1};
    localparam int SF[4] = '{0, 1, 0, 1};
    localparam int RS[2] = '{5, 12};
    localparam int RF[2] = '{0, 1};
    localparam int PS[2] = '{2, 12};
    logic              clk, rst, rd, wr, ana, tick, waitreq, ref_idle;
    logic              smp, st_o, rf_o, run, irq;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata, rdata, e;
    logic [7:0]        tv;
    logic [1:0]        nz;
    logic [3:0]        ctr;
    wire logic [7:0]   term = {tv[7:2], nz};
    logic [31:0]       exp_q[$];
    integer            seed = 13;
    int                n_mismatch, cmp_count, cyc, smp_cnt, st_cnt, ref_cnt, b, b2, n;
    int                d[2];
    atc_top dut (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
        .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hF),
        .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq), .TERMINAL_IN(term),
        .COUNTER_OUT_IN(ctr), .ANALOG_EVENT_IN(ana), .SAMPLE_TICK_IN(tick), .SAMPLE_OUT(smp),
        .WRITE_STROBE_OUT(), .START_TRIG_OUT(st_o), .REF_TRIG_OUT(rf_o), .RUNNING_OUT(run),
        .IRQ_OUT(irq));
    atc_tick_gen u_tick (.clk_in(clk), .rst_in(rst), .period_in(8'h08), .tick_out(tick));
    // ---------------------
    // tasks and monitors
    // ---------------------
    task automatic stop_test();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x) begin
            n_mismatch++;
            $display("Error at %0t: got %0h expected %0h", $time, g, x);
        end
    endtask
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] v);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= v;
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] x);
        exp_q.push_back(x);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic wait_run(input logic v, output int k);
        k = 0;
        while (run !== v && k < 3000) begin
            @(posedge clk);
            k++;
        end
    endtask
    task automatic src(input int s, input logic v);
        @(posedge clk);
        if (s < 8) tv[s] <= v;
        else if (s < 12) ctr[s-8] <= v;
        else ana <= v;
    endtask
    task automatic pulse(input int s, input logic v);
        src(s, v);
        repeat (4) @(posedge clk);
        src(s, !v);
    endtask
    task automatic irq_chk(input logic v);
        repeat (3) @(posedge clk);
        chk(irq, v);
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) nz <= 2'($random(seed));
    always @(negedge clk) begin
        cyc++;
        if (smp === 1'b1) smp_cnt++;
        if (st_o === 1'b1) st_cnt++;
        if (rf_o !== ref_idle) ref_cnt++;
        if (rd === 1'b1 && waitreq === 1'b0 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk(rdata, e);
        end
        if (cyc == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    initial begin
        {rd, wr, ana, ctr, tv, addr, wdata, ref_idle} = '0;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdchk(OFS_CTRL, 32'h0);
        rdchk(OFS_TRIG, RST_TRIG);
        rdchk(OFS_DELAY, RST_DELAY);
        rdchk(OFS_COUNT, RST_COUNT);
        rdchk(OFS_PRE, RST_PRE);
        rdchk(OFS_IRQ_MASK, 32'h0);
        bus(1'b1, OFS_COUNT, 32'h5);
        bus(1'b1, OFS_IRQ_MASK, 32'h1);
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, OFS_DELAY, (i == 1) ? 32'hA : 32'h3);
            b = smp_cnt;
            bus(1'b1, OFS_CTRL, 32'h15);
            wait_run(1'b1, d[i]);
            wait_run(1'b0, n);
            repeat (3) @(posedge clk);
            chk(smp_cnt - b, 5);
        end
        chk(d[1] - d[0], 7);
        irq_chk(1'b1);
        bus(1'b1, OFS_IRQ_MASK, 32'h0);
        irq_chk(1'b0);
        bus(1'b1, OFS_IRQ_MASK, 32'h1);
        irq_chk(1'b1);
        rdchk(OFS_IRQ_STAT, 32'h3);
        bus(1'b1, OFS_IRQ_STAT, 32'h7);
        irq_chk(1'b0);
        rdchk(OFS_IRQ_STAT, 32'h0);
        bus(1'b1, OFS_COUNT, 32'h2);
        for (int i = 0; i < 4; i++) begin
            src(SS[i], 1'(SR[i]));
            bus(1'b1, OFS_TRIG, 32'((1 << TRG_ST_OUT_EN) | (SS[i] << TRG_ST_SRC)
                | (SF[i] << TRG_ST_FALL) | 1));
            b = st_cnt;
            bus(1'b1, OFS_CTRL, 32'h5);
            src(SS[i], !1'(SR[i]));
            repeat (20) @(posedge clk);
            chk(run, 1'b0);
            src(SS[i], 1'(SR[i]));
            wait_run(1'b1, n);
            chk(n < 20, 1'b1);
            wait_run(1'b0, n);
            chk(st_cnt - b, 4);
        end
        bus(1'b1, OFS_COUNT, 32'h8);
        bus(1'b1, OFS_PRE, 32'h3);
        for (int i = 0; i < 2; i++) begin
            src(RS[i], 1'(RF[i]));
            bus(1'b1, OFS_TRIG, 32'((1 << TRG_RF_OUT_EN) | (RF[i] << TRG_RF_OUT_LO)
                | (RS[i] << TRG_RF_SRC) | (RF[i] << TRG_RF_FALL)));
            ref_idle = 1'(RF[i]);
            repeat (2) @(posedge clk);
            b2 = ref_cnt;
            bus(1'b1, OFS_CTRL, 32'hD);
            wait_run(1'b1, n);
            pulse(RS[i], !1'(RF[i]));
            repeat (120) @(posedge clk);
            chk(run, 1'b1);
            chk(ref_cnt - b2, 0);
            @(posedge clk iff smp);
            b = smp_cnt;
            pulse(RS[i], !1'(RF[i]));
            wait_run(1'b0, n);
            repeat (3) @(posedge clk);
            chk(smp_cnt - b, 8 - 3);
            chk(ref_cnt - b2, 1);
        end
        rdchk(OFS_IRQ_STAT, 32'h7);
        for (int i = 0; i < 2; i++) begin
            src(PS[i], 1'(RF[i]));
            bus(1'b1, OFS_TRIG, 32'((1 << TRG_PS_EN) | (RF[i] << TRG_PS_LOW)
                | (PS[i] << TRG_PS_SRC)));
            bus(1'b1, OFS_CTRL, 32'h1);
            wait_run(1'b1, n);
            for (int k = 0; k < 2; k++) begin
                src(PS[i], 1'(RF[i]) ^ (k == 0));
                repeat (6) @(posedge clk);
                b = smp_cnt;
                repeat (64) @(posedge clk);
                chk(smp_cnt - b, k * 8);
            end
            bus(1'b1, OFS_CTRL, 32'h2);
            wait_run(1'b0, n);
            chk(n < 20, 1'b1);
        end
        stop_test();
    end
endmodule
`default_nettype wire
